//--- logic/udtm_top.sv
/*
 * udtm_top: idle timers and access traps for three user devices.
 * Assumes: watched cycles arrive as a one-cycle mon_valid pulse with
 * address, memory/io and write qualifiers, synchronous to hclk.
 */
// Summary of operation
// - enable bit 4 arms device one idle timer
// - enable bit 5 arms device two idle timer
// - enable bit 6 arms device three idle timer
// - trap enable bits 4..6 interrupt on range access
// - trap sets top bit 9 and sub 2..4
// - expiry sets top bit 0 and sub 12..14
// - 16-bit timer decrements each second
// - matching access reloads the device timer
// - 32-bit writable base address per device
// - control bit 7 selects memory or I/O
// - I/O bit 6 enables write tracking
// - I/O bit 5 enables read tracking
// - I/O bits 4..0 mask address 4..0
// - memory bits mask A15..9, ignore A8..0
// - mask bit one excludes address bit
// - registers clear to zero on reset
`default_nettype none

module udtm_top #(
    parameter longint TICK_CYCLES = udtm_pkg::TICK_CYC,
    parameter int     NDEV        = 3
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        mon_valid,
    input  wire logic [31:0] mon_addr,
    input  wire logic        mon_is_mem,
    input  wire logic        mon_write,
    output logic             system_mgmt_interrupt
);

    // ***************************************************************
    // bus slave: one-cycle address capture, zero-wait data phase
    // ***************************************************************
    logic       wr_pend_r;
    logic [7:0] wr_idx_r;
    logic [7:0] rd_idx;
    logic       aph_take;
    logic       tick;
    logic [31:0] tick_cnt_r;

    logic [7:0]  idle_en_r, trap_en_r;
    logic [15:0] cnt_r   [NDEV];
    logic [31:0] base_r  [NDEV];
    logic [7:0]  ctrl_r  [NDEV];
    logic [15:0] timer_r [NDEV];
    logic [NDEV-1:0] run_r;
    logic [NDEV-1:0] hit, expire;
    logic [udtm_pkg::TOP_W-1:0] top_stat_r, top_mask_r, top_set;
    logic [udtm_pkg::SUB_W-1:0] sub_stat_r, sub_mask_r, sub_set;

    assign aph_take = hsel && hready && htrans[1];
    assign rd_idx   = haddr[9:2];

    // registered write target; reads answer in the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 8'h00;
        end else if (hready) begin
            wr_pend_r <= aph_take && hwrite;
            wr_idx_r  <= haddr[9:2];
        end
    end

    // always ready, always okay: every register access is single-cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // read mux, captured at the address phase; unmapped reads as zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (aph_take && !hwrite) begin
            case (rd_idx)
                udtm_pkg::IDX_IDLE_EN:  hrdata <= {24'h000000, idle_en_r};
                udtm_pkg::IDX_TRAP_EN:  hrdata <= {24'h000000, trap_en_r};
                udtm_pkg::IDX_CNT1:     hrdata <= {16'h0000, cnt_r[0]};
                udtm_pkg::IDX_CNT2:     hrdata <= {16'h0000, cnt_r[1]};
                udtm_pkg::IDX_CNT3:     hrdata <= {16'h0000, cnt_r[2]};
                udtm_pkg::IDX_BASE1:    hrdata <= base_r[0];
                udtm_pkg::IDX_BASE2:    hrdata <= base_r[1];
                udtm_pkg::IDX_BASE3:    hrdata <= base_r[2];
                udtm_pkg::IDX_CTRL1:    hrdata <= {24'h000000, ctrl_r[0]};
                udtm_pkg::IDX_CTRL2:    hrdata <= {24'h000000, ctrl_r[1]};
                udtm_pkg::IDX_CTRL3:    hrdata <= {24'h000000, ctrl_r[2]};
                udtm_pkg::IDX_TOP_STAT: hrdata <= {22'h000000, top_stat_r};
                udtm_pkg::IDX_SUB_STAT: hrdata <= {16'h0000, sub_stat_r};
                udtm_pkg::IDX_TOP_MASK: hrdata <= {22'h000000, top_mask_r};
                udtm_pkg::IDX_SUB_MASK: hrdata <= {16'h0000, sub_mask_r};
                default:                hrdata <= 32'h00000000;
            endcase
        end
    end

    // ***************************************************************
    // configuration registers
    // ***************************************************************
    // enables, masks and per-device settings, all clear at reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            idle_en_r  <= udtm_pkg::CTRL_RST;
            trap_en_r  <= udtm_pkg::CTRL_RST;
            top_mask_r <= '0;
            sub_mask_r <= '0;
            for (int i = 0; i < NDEV; i++) begin
                cnt_r[i]  <= udtm_pkg::CNT_RST;
                base_r[i] <= udtm_pkg::BASE_RST;
                ctrl_r[i] <= udtm_pkg::CTRL_RST;
            end
        end else if (wr_pend_r) begin
            case (wr_idx_r)
                udtm_pkg::IDX_IDLE_EN:  idle_en_r  <= hwdata[7:0];
                udtm_pkg::IDX_TRAP_EN:  trap_en_r  <= hwdata[7:0];
                udtm_pkg::IDX_CNT1:     cnt_r[0]   <= hwdata[15:0];
                udtm_pkg::IDX_CNT2:     cnt_r[1]   <= hwdata[15:0];
                udtm_pkg::IDX_CNT3:     cnt_r[2]   <= hwdata[15:0];
                udtm_pkg::IDX_BASE1:    base_r[0]  <= hwdata;
                udtm_pkg::IDX_BASE2:    base_r[1]  <= hwdata;
                udtm_pkg::IDX_BASE3:    base_r[2]  <= hwdata;
                udtm_pkg::IDX_CTRL1:    ctrl_r[0]  <= hwdata[7:0];
                udtm_pkg::IDX_CTRL2:    ctrl_r[1]  <= hwdata[7:0];
                udtm_pkg::IDX_CTRL3:    ctrl_r[2]  <= hwdata[7:0];
                udtm_pkg::IDX_TOP_MASK: top_mask_r <= hwdata[9:0];
                udtm_pkg::IDX_SUB_MASK: sub_mask_r <= hwdata[15:0];
                default: ;
            endcase
        end
    end

    // ***************************************************************
    // one second timebase
    // ***************************************************************
    // free-running divider; a reload may thus lose up to one second
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tick_cnt_r <= 32'h00000000;
            tick       <= 1'b0;
        end else if (tick_cnt_r == 32'(TICK_CYCLES - 1)) begin
            tick_cnt_r <= 32'h00000000;
            tick       <= 1'b1;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h00000001;
            tick       <= 1'b0;
        end
    end

    // ***************************************************************
    // address decode per device
    // ***************************************************************
    always_comb begin
        logic [31:0] care;
        care = '0;
        for (int i = 0; i < NDEV; i++) begin
            care = 32'hffffffff;
            if (ctrl_r[i][udtm_pkg::CTL_MEM_BIT]) begin
                // low nine bits never compared, mask covers 15..9
                care[8:0] = 9'h000;
                care[15:9] = ~ctrl_r[i][6:0];
                hit[i] = mon_valid && mon_is_mem &&
                         ((mon_addr & care) == (base_r[i] & care));
            end else begin
                care[4:0] = ~ctrl_r[i][4:0];
                hit[i] = mon_valid && !mon_is_mem &&
                         ((mon_addr & care) == (base_r[i] & care)) &&
                         (mon_write ? ctrl_r[i][udtm_pkg::CTL_WR_BIT]
                                    : ctrl_r[i][udtm_pkg::CTL_RD_BIT]);
            end
        end
    end

    // ***************************************************************
    // idle timers
    // ***************************************************************
    // run_r drops on expiry so a stale zero cannot re-fire every cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < NDEV; i++) begin
                timer_r[i] <= 16'h0000;
                run_r[i]   <= 1'b0;
            end
        end else begin
            for (int i = 0; i < NDEV; i++) begin
                if (!idle_en_r[udtm_pkg::IDLE_EN_LSB+i]) begin
                    timer_r[i] <= cnt_r[i];
                    run_r[i]   <= 1'b1;
                end else if (hit[i]) begin
                    timer_r[i] <= cnt_r[i];
                    run_r[i]   <= 1'b1;
                end else if (expire[i]) begin
                    run_r[i]   <= 1'b0;
                end else if (tick && run_r[i] && timer_r[i] != 16'h0000) begin
                    timer_r[i] <= timer_r[i] - 16'h0001;
                end
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NDEV; i++) begin
            expire[i] = idle_en_r[udtm_pkg::IDLE_EN_LSB+i] && run_r[i] &&
                        !hit[i] && timer_r[i] == 16'h0000;
        end
    end

    // ***************************************************************
    // status and interrupt
    // ***************************************************************
    always_comb begin
        top_set = '0;
        sub_set = '0;
        for (int i = 0; i < NDEV; i++) begin
            if (hit[i] && trap_en_r[udtm_pkg::TRAP_EN_LSB+i]) begin
                top_set[udtm_pkg::TOP_TRAP_BIT]   = 1'b1;
                sub_set[udtm_pkg::SUB_TRAP_LSB+i] = 1'b1;
            end
            if (expire[i]) begin
                top_set[udtm_pkg::TOP_IDLE_BIT] = 1'b1;
                sub_set[udtm_pkg::SUB_IDLE_OFS+udtm_pkg::SUB_IDLE_LSB+i] = 1'b1;
            end
        end
    end

    // write one to clear; a set in the same cycle wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            top_stat_r <= '0;
            sub_stat_r <= '0;
        end else begin
            top_stat_r <= (top_stat_r & ~((wr_pend_r &&
                          wr_idx_r == udtm_pkg::IDX_TOP_STAT) ?
                          hwdata[9:0] : 10'h000)) | top_set;
            sub_stat_r <= (sub_stat_r & ~((wr_pend_r &&
                          wr_idx_r == udtm_pkg::IDX_SUB_STAT) ?
                          hwdata[15:0] : 16'h0000)) | sub_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            system_mgmt_interrupt <= 1'b0;
        end else begin
            system_mgmt_interrupt <= |(top_stat_r & top_mask_r) ||
                                     |(sub_stat_r & sub_mask_r);
        end
    end

    // ***************************************************************
    // checks
    // ***************************************************************
    property p_trap_top;
        @(posedge hclk) disable iff (!hresetn)
        (hit[0] && trap_en_r[udtm_pkg::TRAP_EN_LSB]) |=>
            top_stat_r[udtm_pkg::TOP_TRAP_BIT] && sub_stat_r[2];
    endproperty
    a_trap_top: assert property (p_trap_top)
        else $error("trap did not set status");

    property p_idle_top;
        @(posedge hclk) disable iff (!hresetn)
        expire[1] |=> top_stat_r[0] && sub_stat_r[13];
    endproperty
    a_idle_top: assert property (p_idle_top)
        else $error("expiry did not set status");

    property p_reload;
        @(posedge hclk) disable iff (!hresetn)
        hit[2] |=> timer_r[2] == $past(cnt_r[2]);
    endproperty
    a_reload: assert property (p_reload)
        else $error("timer not reloaded on hit");

    property p_no_tick_hold;
        @(posedge hclk) disable iff (!hresetn)
        (!tick && !hit[0] && idle_en_r[4]) |=> $stable(timer_r[0]);
    endproperty
    a_no_tick_hold: assert property (p_no_tick_hold)
        else $error("timer moved without tick");

    property p_dec;
        @(posedge hclk) disable iff (!hresetn)
        (tick && run_r[0] && idle_en_r[4] && !hit[0] &&
         timer_r[0] != 16'h0000) |=> timer_r[0] == $past(timer_r[0]) - 16'h0001;
    endproperty
    a_dec: assert property (p_dec)
        else $error("timer did not decrement");

    property p_io_wr;
        @(posedge hclk) disable iff (!hresetn)
        (mon_valid && mon_write && !ctrl_r[1][7] && !ctrl_r[1][6]) |-> !hit[1];
    endproperty
    a_io_wr: assert property (p_io_wr)
        else $error("untracked write counted");

    property p_io_rd;
        @(posedge hclk) disable iff (!hresetn)
        (mon_valid && !mon_write && !ctrl_r[1][7] && !ctrl_r[1][5]) |-> !hit[1];
    endproperty
    a_io_rd: assert property (p_io_rd)
        else $error("untracked read counted");

    property p_space;
        @(posedge hclk) disable iff (!hresetn)
        (mon_valid && mon_is_mem != ctrl_r[0][7]) |-> !hit[0];
    endproperty
    a_space: assert property (p_space)
        else $error("wrong space matched");

    property p_irq;
        @(posedge hclk) disable iff (!hresetn)
        (top_stat_r[9] && top_mask_r[9]) |=> system_mgmt_interrupt;
    endproperty
    a_irq: assert property (p_irq)
        else $error("interrupt not raised");

    // third device trap lands in its own second-level bit
    property p_trap_dev3;
        @(posedge hclk) disable iff (!hresetn)
        (hit[2] && trap_en_r[udtm_pkg::TRAP_EN_LSB+2]) |=>
            top_stat_r[udtm_pkg::TOP_TRAP_BIT] &&
            sub_stat_r[udtm_pkg::SUB_TRAP_LSB+2];
    endproperty
    a_trap_dev3: assert property (p_trap_dev3)
        else $error("third device trap not flagged");

    // expiry fires once: the timer parks at zero until a reload
    property p_expire_stop;
        @(posedge hclk) disable iff (!hresetn)
        expire[0] |=> !run_r[0] && timer_r[0] == 16'h0000;
    endproperty
    a_expire_stop: assert property (p_expire_stop)
        else $error("timer kept running after expiry");

    // low nine address bits never decide a memory match
    property p_mem_low;
        @(posedge hclk) disable iff (!hresetn)
        (mon_valid && mon_is_mem && ctrl_r[2][udtm_pkg::CTL_MEM_BIT] &&
         mon_addr[31:udtm_pkg::MEM_MASK_LSB] ==
         base_r[2][31:udtm_pkg::MEM_MASK_LSB]) |-> hit[2];
    endproperty
    a_mem_low: assert property (p_mem_low)
        else $error("memory match depended on low bits");

    // a set mask bit lets address bit 0 differ on an I/O read
    property p_io_mask;
        @(posedge hclk) disable iff (!hresetn)
        (mon_valid && !mon_is_mem && !mon_write && ctrl_r[0][0] &&
         !ctrl_r[0][udtm_pkg::CTL_MEM_BIT] &&
         ctrl_r[0][udtm_pkg::CTL_RD_BIT] &&
         mon_addr[31:1] == base_r[0][31:1]) |-> hit[0];
    endproperty
    a_io_mask: assert property (p_io_mask)
        else $error("masked address bit still compared");

endmodule // udtm_top

`default_nettype wire

//--- pkg/udtm_pkg.sv
/*
 * udtm_pkg: register indices, field positions, reset values and timing
 * constants of the user device idle/trap monitor.
 * Assumes a 32-bit AHB-Lite register bus; registers sit at index*4.
 */
`default_nettype none

package udtm_pkg;

    // ***************************************************************
    // register indices (byte address is index times four)
    // ***************************************************************
    localparam logic [7:0] IDX_IDLE_EN   = 8'h81;
    localparam logic [7:0] IDX_TRAP_EN   = 8'h82;
    localparam logic [7:0] IDX_CNT1      = 8'ha0;
    localparam logic [7:0] IDX_CNT2      = 8'ha2;
    localparam logic [7:0] IDX_CNT3      = 8'ha4;
    localparam logic [7:0] IDX_BASE1     = 8'hc0;
    localparam logic [7:0] IDX_BASE2     = 8'hc4;
    localparam logic [7:0] IDX_BASE3     = 8'hc8;
    localparam logic [7:0] IDX_CTRL1     = 8'hcc;
    localparam logic [7:0] IDX_CTRL2     = 8'hcd;
    localparam logic [7:0] IDX_CTRL3     = 8'hce;
    localparam logic [7:0] IDX_TOP_STAT  = 8'he0;
    localparam logic [7:0] IDX_SUB_STAT  = 8'he1;
    localparam logic [7:0] IDX_TOP_MASK  = 8'he2;
    localparam logic [7:0] IDX_SUB_MASK  = 8'he3;

    // ***************************************************************
    // field positions
    // ***************************************************************
    localparam int IDLE_EN_LSB   = 4;   // bits 4..6, one per device
    localparam int TRAP_EN_LSB   = 4;   // bits 4..6
    localparam int TOP_IDLE_BIT  = 0;
    localparam int TOP_TRAP_BIT  = 9;
    localparam int SUB_TRAP_LSB  = 2;   // bits 2..4
    localparam int SUB_IDLE_LSB  = 4;   // bits 12..14 with SUB_IDLE_OFS (second status word)
    localparam int CTL_MEM_BIT   = 7;
    localparam int CTL_WR_BIT    = 6;
    localparam int CTL_RD_BIT    = 5;
    localparam int IO_MASK_W     = 5;
    localparam int MEM_MASK_W    = 7;
    localparam int MEM_MASK_LSB  = 9;
    localparam int TOP_W         = 10;
    localparam int SUB_W         = 16;  // trap bits 2..4, idle bits 8+4..6
    localparam int SUB_IDLE_OFS  = 8;

    // ***************************************************************
    // reset values and timing
    // ***************************************************************
    localparam logic [7:0]  CTRL_RST  = 8'h00;
    localparam logic [15:0] CNT_RST   = 16'h0000;
    localparam logic [31:0] BASE_RST  = 32'h00000000;
    localparam longint CLK_HZ         = 50000000;
    localparam longint TICK_S         = 1;
    localparam longint TICK_CYC       = CLK_HZ * TICK_S;

    typedef enum logic [1:0] {
        UDTM_AIDLE = 2'b00,
        UDTM_ADATA = 2'b01
    } udtm_aph_e;

endpackage : udtm_pkg

`default_nettype wire

//--- sim/tb.sv
/*
 * tb: self-checking bench for udtm_top; expected read data queue up
 * and a watcher compares them in each read data phase that rd() marks for checking.
 * Assumes one 50 MHz clock and a timer tick shortened to 10 cycles.
 */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ***************************************************************
    // signals and instances
    // ***************************************************************
    localparam int TK = 10;
    typedef struct { string nm; logic [31:0] v; } udtm_exp_s;
    logic        hclk, hresetn, hsel, hwrite, rd_chk;
    logic        dph = 1'b0;
    logic [31:0] haddr, hwdata, hrdata, rdv, base;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic        hreadyout, hresp, irq;
    wire logic   mv, mm, mw;
    wire logic [31:0] ma;
    wire logic   hready;
    udtm_exp_s   exp_q [$];
    udtm_exp_s   e_w;
    logic        irq_q [$];
    event        irq_ev;
    int          num_errors = 0;
    int          cmp_count  = 0;
    logic [7:0]  ridx [11] = '{udtm_pkg::IDX_IDLE_EN, udtm_pkg::IDX_TRAP_EN,
        udtm_pkg::IDX_CNT1, udtm_pkg::IDX_CNT2, udtm_pkg::IDX_CNT3,
        udtm_pkg::IDX_BASE1, udtm_pkg::IDX_BASE2, udtm_pkg::IDX_BASE3,
        udtm_pkg::IDX_CTRL1, udtm_pkg::IDX_CTRL2, udtm_pkg::IDX_CTRL3};
    logic [31:0] rmsk [11] = '{32'hff, 32'hff, 32'hffff, 32'hffff,
        32'hffff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
        32'hff, 32'hff, 32'hff};

    // the one slave's ready is the bus ready
    assign hready = hreadyout;

    udtm_top #(.TICK_CYCLES(TK)) uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .mon_valid(mv), .mon_addr(ma), .mon_is_mem(mm),
        .mon_write(mw), .system_mgmt_interrupt(irq));

    udtm_host_model host (.hclk(hclk), .mon_valid(mv), .mon_addr(ma),
        .mon_is_mem(mm), .mon_write(mw));

    // ***************************************************************
    // compares and watchers
    // ***************************************************************
    task automatic cmp_word(input string nm, input logic [31:0] e,
                            input logic [31:0] s);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic cmp_bit(input string nm, input logic e, input logic s);
        cmp_count++;
        if (s !== e) begin
            num_errors++;
            $display("BAD %s expected %b seen %b", nm, e, s);
        end
    endtask

    // read data are taken at the edge that ends the data phase
    always @(posedge hclk) begin
        if (hready === 1'b1) begin
            if (dph) begin
                e_w = exp_q.pop_front();
                cmp_word(e_w.nm, e_w.v, hrdata);
                cmp_bit("okay response", 1'b0, hresp);
            end
            dph <= hsel & htrans[1] & ~hwrite & rd_chk;
        end
    end

    always @(irq_ev) cmp_bit("interrupt", irq_q.pop_front(), irq);

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // ***************************************************************
    // bus and scenario tasks
    // ***************************************************************
    // bounded wait for hready high at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hready !== 1'b1) begin
            n++;
            if (n > 50) begin
                num_errors++;
                tally_and_finish();
            end
            @(posedge hclk);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] ix,
                       input logic [31:0] wd, input logic c);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        rd_chk <= c;
        haddr  <= {22'h0, ix, 2'b00};
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rdv = hrdata;
    endtask

    task automatic wr(input logic [7:0] ix, input logic [31:0] d);
        bus(1'b1, ix, d, 1'b0);
    endtask

    task automatic rd(input logic [7:0] ix, input logic [31:0] e,
                      input string nm);
        exp_q.push_back('{nm, e});
        bus(1'b0, ix, 32'h0, 1'b1);
    endtask

    // irq is registered behind status: look one edge on, mid-cycle
    task automatic chk_irq(input logic e);
        @(posedge hclk);
        @(negedge hclk);
        irq_q.push_back(e);
        -> irq_ev;
        @(posedge hclk);
    endtask

    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
    endtask

    task automatic clr_stat();
        wr(udtm_pkg::IDX_TOP_STAT, 32'h201);
        wr(udtm_pkg::IDX_SUB_STAT, 32'hffff);
        chk_irq(1'b0);
    endtask

    // one watched cycle against device d; h says whether it must trap
    task automatic trap_try(input int d, input logic [7:0] c,
        input logic [31:0] f, input logic m, input logic w, input logic h);
        base = $urandom;
        wr(udtm_pkg::IDX_BASE1 + 8'(4 * d), base);
        wr(udtm_pkg::IDX_CTRL1 + 8'(d), {24'h0, c});
        wr(udtm_pkg::IDX_TRAP_EN, 32'h10 << d);
        host.cycle(base ^ f, m, w);
        repeat (3) @(posedge hclk);
        chk_irq(h);
        rd(udtm_pkg::IDX_TOP_STAT, h ? 32'h200 : 32'h0, "top trap");
        rd(udtm_pkg::IDX_SUB_STAT, h ? 32'h4 << d : 32'h0, "sub trap");
        clr_stat();
    endtask

    // hits keep the timer reloaded, then it must run out in time
    task automatic idle_try(input int d);
        int  n;
        time t0;
        base = $urandom;
        wr(udtm_pkg::IDX_BASE1 + 8'(4 * d), base);
        wr(udtm_pkg::IDX_CTRL1 + 8'(d), 32'h80);
        wr(udtm_pkg::IDX_TRAP_EN, 32'h0); // no trap bits in idle status
        wr(udtm_pkg::IDX_CNT1 + 8'(2 * d), 32'h3);
        wr(udtm_pkg::IDX_IDLE_EN, 32'h10 << d);
        repeat (8) begin
            host.cycle(base ^ 32'h1ff, 1'b1, d[0]);
            repeat (11) @(posedge hclk);
        end
        t0 = $time - 220;
        rd(udtm_pkg::IDX_SUB_STAT, 32'h0, "idle reloaded");
        n = 0;
        rdv = 32'h0;
        while (rdv[12 + d] !== 1'b1 && n < 100) begin
            bus(1'b0, udtm_pkg::IDX_SUB_STAT, 32'h0, 1'b0);
            n++;
        end
        n = int'(($time - t0) / 20);
        cmp_bit("expiry time", 1'b1, n >= 2 * TK && n <= 5 * TK);
        rd(udtm_pkg::IDX_TOP_STAT, 32'h1, "top idle");
        rd(udtm_pkg::IDX_SUB_STAT, 32'h1000 << d, "sub idle");
        chk_irq(1'b1);
        wr(udtm_pkg::IDX_IDLE_EN, 32'h0);
        clr_stat();
    endtask

    // ***************************************************************
    // main sequence
    // ***************************************************************
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end

    initial begin
        {hsel, hwrite, rd_chk, hresetn} = '0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'b010;
        void'($urandom(89));
        do_reset();
        foreach (ridx[i]) rd(ridx[i], 32'h0, "reset value");
        foreach (ridx[i]) begin
            base = $urandom;
            wr(ridx[i], base);
            rd(ridx[i], base & rmsk[i], "readback");
        end
        rd(8'h10, 32'h0, "unmapped");
        do_reset();
        foreach (ridx[i]) rd(ridx[i], 32'h0, "second reset");
        $display("test registers done");
        wr(udtm_pkg::IDX_TOP_MASK, 32'h201);
        wr(udtm_pkg::IDX_SUB_MASK, 32'h701c);
        for (int d = 0; d < 3; d++) trap_try(d, 8'h60, 32'h0, 1'b0, 1'b0, 1'b1);
        trap_try(0, 8'h60, 32'h0, 1'b0, 1'b1, 1'b1);
        trap_try(0, 8'h20, 32'h0, 1'b0, 1'b1, 1'b0);
        trap_try(0, 8'h40, 32'h0, 1'b0, 1'b0, 1'b0);
        trap_try(0, 8'h60, 32'h1, 1'b0, 1'b0, 1'b0);
        trap_try(0, 8'h61, 32'h1, 1'b0, 1'b0, 1'b1);
        trap_try(0, 8'h7f, 32'h20, 1'b0, 1'b0, 1'b0);
        trap_try(1, 8'h60, 32'h0, 1'b1, 1'b0, 1'b0);
        trap_try(1, 8'h80, 32'h0, 1'b0, 1'b0, 1'b0);
        trap_try(1, 8'h80, 32'h1ff, 1'b1, 1'b0, 1'b1);
        trap_try(2, 8'h80, 32'h1ff, 1'b1, 1'b1, 1'b1);
        trap_try(2, 8'h80, 32'h200, 1'b1, 1'b0, 1'b0);
        trap_try(2, 8'hff, 32'hfe00, 1'b1, 1'b1, 1'b1);
        trap_try(2, 8'hbf, 32'h10000, 1'b1, 1'b0, 1'b0);
        $display("test traps done");
        wr(udtm_pkg::IDX_TOP_MASK, 32'h0);
        wr(udtm_pkg::IDX_SUB_MASK, 32'h0);
        host.cycle(base ^ 32'h7e00, 1'b1, 1'b0);
        repeat (3) @(posedge hclk);
        chk_irq(1'b0);
        wr(udtm_pkg::IDX_SUB_MASK, 32'h10);
        chk_irq(1'b1);
        clr_stat();
        wr(udtm_pkg::IDX_TOP_MASK, 32'h201);
        wr(udtm_pkg::IDX_SUB_MASK, 32'h701c);
        $display("test masking done");
        idle_try(0);
        idle_try(1);
        idle_try(2);
        $display("test idle timers done");
        tally_and_finish();
    end
endmodule // tb

`default_nettype wire

//--- sim/udtm_host_model.sv
/*
 * udtm_host_model: the host side whose cycles the monitor watches.
 * Assumes the bench calls cycle() from one process, clocked by hclk.
 */
`default_nettype none

module udtm_host_model (
    input  wire logic        hclk,
    output logic             mon_valid,
    output logic [31:0]      mon_addr,
    output logic             mon_is_mem,
    output logic             mon_write
);
    timeunit 1ns;
    timeprecision 1ps;

    // ***************************************************************
    // one watched cycle
    // ***************************************************************
    initial begin
        mon_valid  = 1'b0;
        mon_addr   = 32'h0;
        mon_is_mem = 1'b0;
        mon_write  = 1'b0;
    end

    // one-cycle pulse; qualifiers flip afterwards so stale values never match
    task automatic cycle(input logic [31:0] a, input logic m, input logic w);
        @(posedge hclk);
        mon_valid  <= 1'b1;
        mon_addr   <= a;
        mon_is_mem <= m;
        mon_write  <= w;
        @(posedge hclk);
        mon_valid  <= 1'b0;
        mon_addr   <= ~a;
        mon_is_mem <= ~m;
        mon_write  <= ~w;
    endtask
endmodule // udtm_host_model

`default_nettype wire
